// >>> rtl/scr_pkg.sv
// Shared constants and types of the management-bus register access block.
// Assumes one core clock; bus pins are synchronised before any use.
package scr_pkg;

    // Command codes carried in the byte after the slave address, then byte counts, operation bits, fixed address and error code values
    localparam logic [7:0] CMD_WR = 8'hBE;
    localparam logic [7:0] CMD_SETUP = 8'hBA;
    localparam logic [7:0] CMD_RD = 8'hBD;
    localparam logic [7:0] CMD_PCALL = 8'hCD;
    localparam logic [7:0] CNT_WR = 8'h08;
    localparam logic [7:0] CNT_SETUP = 8'h04;
    localparam logic [7:0] CNT_RET = 8'h04;
    localparam logic [2:0] OP_WR = 3'h3;
    localparam logic [2:0] OP_RD = 3'h4;
    localparam logic [3:0] ADDR_FIXED = 4'hD;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] CRC_GOOD = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // Received byte positions within one frame, address byte first, then bits per byte
    localparam logic [3:0] BI_ADDR = 4'h0;
    localparam logic [3:0] BI_CMD = 4'h1;
    localparam logic [3:0] BI_CNT = 4'h2;
    localparam logic [3:0] BI_CB1 = 4'h3;
    localparam logic [3:0] BI_CB2 = 4'h4;
    localparam logic [3:0] BI_CB3 = 4'h5;
    localparam logic [3:0] BI_CB4 = 4'h6;
    localparam logic [3:0] BI_SPEC = 4'h7;
    localparam logic [3:0] BI_D4 = 4'hA;
    localparam logic [3:0] BI_WPEC = 4'hB;
    localparam logic [3:0] BI_MAX = 4'hF;
    localparam logic [3:0] BITS = 4'h8;
    // Returned byte positions
    localparam logic [2:0] TI_CNT = 3'h0;
    localparam logic [2:0] TI_PEC = 3'h5;
    localparam logic [2:0] TI_MAX = 3'h7;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } scr_ev_t;

    typedef struct packed {
        logic [4:0] port;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } scr_wr_t;

    typedef struct packed {
        logic [4:0] port;
        logic [11:0] addr;
    } scr_tgt_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } scr_st_t;

    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
    } scr_line_t;

    typedef struct packed {
        scr_st_t st;
        logic [7:0] sh;
        logic [3:0] bcnt;
        logic [3:0] bidx;
        logic [2:0] tidx;
        logic rd_dir;
        logic [7:0] cmd;
        logic bad;
        logic ack;
        logic frame;
        logic pend;
        logic setup;
        logic rd_arm;
        scr_wr_t tgt;
        scr_tgt_t rtgt;
        logic [31:0] rdat;
        logic [2:0] strap1;
        logic [2:0] strap2;
        logic ovr;
        logic [6:0] saddr;
        logic sda_oe;
        logic drv0;
        logic wr_req;
        scr_wr_t wr;
        logic rd_req;
        scr_tgt_t rd;
    } scr_top_t;

endpackage

// >>> rtl/scr_line.sv
// Pin synchroniser and bus condition detector for clock and data lines.
// Assumes both lines idle high; the first flop of each chain feeds only the second.
`timescale 1ns/100ps
module scr_line (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_scl,
    input wire logic i_sda,
    output scr_pkg::scr_ev_t o_ev
);
    import scr_pkg::*;

    scr_line_t q;
    scr_line_t d;

    ////////////////////////////////////////////////////////////////////////////
    // Three taps: two to synchronise, a third to find edges
    always_comb begin
        d.scl = {q.scl[1:0], i_scl};
        d.sda = {q.sda[1:0], i_sda};
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '1;
        end else if (i_ce) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data moving while the clock is high marks start and stop
    assign o_ev.rise = q.scl[1] & ~q.scl[2];
    assign o_ev.fall = ~q.scl[1] & q.scl[2];
    assign o_ev.start = q.scl[1] & q.scl[2] & q.sda[2] & ~q.sda[1];
    assign o_ev.stop = q.scl[1] & q.scl[2] & ~q.sda[2] & q.sda[1];
    assign o_ev.sda = q.sda[1];

endmodule // scr_line

// >>> rtl/scr_crc8.sv
// Bit-serial error code, polynomial x^8+x^2+x+1, MSB first.
// Assumes bits arrive one per enable, in bus order.
`timescale 1ns/100ps
module scr_crc8 (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_en,
    input wire logic i_bit,
    output logic [7:0] o_crc
);
    import scr_pkg::*;

    logic [7:0] q;
    logic [7:0] d;

    ////////////////////////////////////////////////////////////////////////////
    // Clear wins so a new frame never inherits old bits
    always_comb begin
        d = q;
        if (i_clr) begin
            d = CRC_INIT;
        end else if (i_en) begin
            d = {q[6:0], 1'b0} ^ ((q[7] ^ i_bit) ? CRC_POLY : 8'h00);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= CRC_INIT;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_crc = q;

endmodule // scr_crc8

// >>> rtl/scr_slave.sv
// Management-bus slave giving a bus master access to 32-bit config registers.
// Assumes a register file beside it that answers a read request with i_rd_ack.
// Behaviour
// - Slave only; both lines open drain, clock never driven.
// - Address is 1101 followed by the three strap bits.
// - Software may load its own 7-bit address instead.
// - All registers writable, read-only and hardware initialised included.
// - Command BE starts a register write.
// - BA sets up a read, BD then returns the data.
// - Process call CD sets up and reads in one transaction.
// - Write byte count must be 8; error code byte not counted.
// - A wrong byte and all later bytes of the packet are refused.
// - Byte after the fourth data byte is the error code.
// - Bad error code drops the write and refuses that byte.
// - Error code check skipped while the check-off bit is set.
// - First command byte bits 2:0: 011 write, 100 read.
// - Port is byte2 bits 3:0 above byte3 bit 7.
// - Byte3 bits 5:2 enable register bytes 0 through 3.
// - Address 11:10 from byte3, 9:2 from byte4, 1:0 zero.
// - Write data arrives most significant byte first.
// - Error codes checked on receive and generated on return.
// - Read returns count four then data bits 31:24 down to 7:0.
// - One extra requested byte gets the error code; master refusal ends read.
`timescale 1ns/100ps
module scr_slave (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_o,
    output logic o_scl_oe,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic [2:0] i_strap,
    input wire logic [6:0] i_ctl_addr,
    input wire logic i_ctl_addr_wr,
    input wire logic i_integrity_check_off,
    output logic [6:0] o_slave_addr,
    output logic o_wr_req,
    output scr_pkg::scr_wr_t o_wr,
    output logic o_rd_req,
    output scr_pkg::scr_tgt_t o_rd,
    input wire logic i_rd_ack,
    input wire logic [31:0] i_rd_data
);
    import scr_pkg::*;

    scr_top_t q;
    scr_top_t d;
    scr_ev_t ev;
    logic [7:0] crc;
    logic rx_done;
    logic [7:0] crc_fin;

    ////////////////////////////////////////////////////////////////////////////
    // Bus edges and the running error code over every data bit seen
    scr_line u_line (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_ev(ev)
    );

    // Bits enter at the fall that ends them: the rise before a repeated start never counts
    scr_crc8 u_crc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_clr(ev.stop | (ev.start & ~q.frame)),
        .i_en(ev.fall & (((q.st == ST_RX) & (q.bcnt != 4'h0)) | (q.st == ST_TX))),
        .i_bit((q.st == ST_TX) ? ~q.sda_oe : q.sh[0]),
        .o_crc(crc)
    );

    assign rx_done = i_ce & (q.st == ST_RX) & ev.fall & (q.bcnt == BITS);
    // Code with the last bit of the byte just received folded in
    assign crc_fin = {crc[6:0], 1'b0} ^ ((crc[7] ^ q.sh[0]) ? CRC_POLY : 8'h00);

    // Byte returned at each position of a read
    function automatic logic [7:0] tx_byte(input logic [2:0] ti, input logic [31:0] dat,
                                           input logic [7:0] code);
        case (ti)
            3'h0: tx_byte = CNT_RET;
            3'h1: tx_byte = dat[31:24];
            3'h2: tx_byte = dat[23:16];
            3'h3: tx_byte = dat[15:8];
            3'h4: tx_byte = dat[7:0];
            3'h5: tx_byte = code;
            default: tx_byte = IDLE_BYTE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the whole slave
    always_comb begin
        logic [7:0] b;
        logic ok;
        logic [7:0] nb;
        b = q.sh;
        ok = ~q.bad;
        nb = 8'h00;
        d = q;
        d.wr_req = 1'b0;
        d.rd_req = 1'b0;
        // Straps are followed until software takes the address over
        d.strap1 = i_strap;
        d.strap2 = q.strap1;
        if (i_ctl_addr_wr) begin
            d.ovr = 1'b1;
            d.saddr = i_ctl_addr;
        end else if (!q.ovr) begin
            d.saddr = {ADDR_FIXED, q.strap2};
        end
        if (i_rd_ack) begin
            d.rdat = i_rd_data;
        end
        if (ev.stop || ev.start) begin
            // A pending write without error code lands at the frame's end
            if (q.pend) begin
                d.wr_req = 1'b1;
                d.wr = q.tgt;
                d.pend = 1'b0;
            end
            d.sda_oe = 1'b0;
            d.bad = 1'b0;
            d.bidx = BI_ADDR;
            d.bcnt = 4'h0;
            d.rd_dir = 1'b0;
            d.frame = ev.start;
            d.rd_arm = ev.start & q.frame & q.rd_arm;
            d.st = ev.start ? ST_RX : ST_IDLE;
        end else begin
            case (q.st)
                ST_RX: begin
                    if (ev.rise) begin
                        d.sh = {q.sh[6:0], ev.sda};
                        d.bcnt = q.bcnt + 4'h1;
                    end else if (rx_done) begin
                        d.bcnt = 4'h0;
                        d.st = ST_ACK;
                        case (q.bidx)
                            BI_ADDR: begin
                                if (b[7:1] != q.saddr) begin
                                    ok = 1'b0;
                                    d.st = ST_IDLE;
                                end else if (b[0]) begin
                                    ok = ok & q.rd_arm & q.setup;
                                    if (ok) begin
                                        d.rd_dir = 1'b1;
                                        d.tidx = TI_CNT;
                                        d.rd_req = 1'b1;
                                        d.rd = q.rtgt;
                                    end else begin
                                        d.st = ST_IDLE;
                                    end
                                end
                            end
                            BI_CMD: begin
                                ok = ok & ((b == CMD_WR) | (b == CMD_SETUP)
                                    | (b == CMD_RD) | (b == CMD_PCALL));
                                d.cmd = b;
                                d.rd_arm = ok & (b == CMD_RD);
                            end
                            BI_CNT: begin
                                // Read command takes no count; the others a fixed one
                                ok = ok & (q.cmd != CMD_RD)
                                    & (b == ((q.cmd == CMD_WR) ? CNT_WR : CNT_SETUP));
                            end
                            BI_CB1: begin
                                ok = ok & (b[2:0] == ((q.cmd == CMD_WR) ? OP_WR : OP_RD));
                                if (ok && q.cmd != CMD_WR) begin
                                    d.setup = 1'b0;
                                end
                            end
                            BI_CB2: begin
                                d.tgt.port[4:1] = b[3:0];
                            end
                            BI_CB3: begin
                                d.tgt.port[0] = b[7];
                                d.tgt.be = b[5:2];
                                d.tgt.addr[11:10] = b[1:0];
                            end
                            BI_CB4: begin
                                d.tgt.addr = {q.tgt.addr[11:10], b, 2'b00};
                                if (ok && q.cmd != CMD_WR) begin
                                    d.setup = 1'b1;
                                    d.rtgt.port = q.tgt.port;
                                    d.rtgt.addr = {q.tgt.addr[11:10], b, 2'b00};
                                    d.rd_arm = (q.cmd == CMD_PCALL);
                                end
                            end
                            default: begin
                                if (q.cmd == CMD_WR && q.bidx <= BI_D4) begin
                                    d.tgt.data = {q.tgt.data[23:0], b};
                                    if (ok && q.bidx == BI_D4) begin
                                        d.pend = 1'b1;
                                    end
                                end else if ((q.cmd == CMD_WR && q.bidx == BI_WPEC)
                                    || (q.cmd != CMD_WR && q.bidx == BI_SPEC)) begin
                                    // Remainder over message plus code is zero when good
                                    ok = ok & (i_integrity_check_off | (crc_fin == CRC_GOOD));
                                    if (q.cmd == CMD_WR) begin
                                        d.pend = 1'b0;
                                        if (ok && q.pend) begin
                                            d.wr_req = 1'b1;
                                            d.wr = q.tgt;
                                        end
                                    end else if (!ok) begin
                                        d.setup = 1'b0;
                                        d.rd_arm = 1'b0;
                                    end
                                end else begin
                                    ok = 1'b0;
                                end
                            end
                        endcase
                        // A refusal sticks until the next start or stop
                        d.bad = q.bad | ~ok;
                        d.ack = ok;
                        d.sda_oe = ok & (d.st == ST_ACK);
                        if (q.bidx != BI_MAX) begin
                            d.bidx = q.bidx + 4'h1;
                        end
                    end
                end
                ST_ACK: begin
                    if (ev.fall) begin
                        if (q.rd_dir) begin
                            nb = tx_byte(q.tidx, q.rdat, crc);
                            d.sh = nb;
                            d.sda_oe = ~nb[7];
                            d.bcnt = 4'h1;
                            d.st = ST_TX;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.st = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    // Next bit goes out on each falling clock
                    if (ev.fall) begin
                        if (q.bcnt == BITS) begin
                            d.sda_oe = 1'b0;
                            d.st = ST_MACK;
                        end else begin
                            d.sda_oe = ~q.sh[6];
                            d.sh = {q.sh[6:0], 1'b0};
                            d.bcnt = q.bcnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (ev.rise) begin
                        d.ack = ~ev.sda;
                    end else if (ev.fall) begin
                        if (q.ack) begin
                            d.tidx = (q.tidx == TI_MAX) ? TI_MAX : q.tidx + 3'h1;
                            nb = tx_byte(d.tidx, q.rdat, crc);
                            d.sh = nb;
                            d.sda_oe = ~nb[7];
                            d.bcnt = 4'h1;
                            d.st = ST_TX;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                default: begin
                    d.st = ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // All state frozen while the clock enable is low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.st <= ST_IDLE;
        end else if (i_ce) begin
            q <= d;
        end
    end

    // Outputs straight from flops; the clock pin is never pulled
    assign o_scl_o = q.drv0;
    assign o_scl_oe = q.drv0;
    assign o_sda_o = q.drv0;
    assign o_sda_oe = q.sda_oe;
    assign o_slave_addr = q.saddr;
    assign o_wr_req = q.wr_req;
    assign o_wr = q.wr;
    assign o_rd_req = q.rd_req;
    assign o_rd = q.rd;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_cnt_bad;
        rx_done && q.bidx == BI_CNT && q.cmd == CMD_WR && q.sh != CNT_WR;
    endsequence
    sequence s_wpec_bad;
        rx_done && q.bidx == BI_WPEC && q.cmd == CMD_WR && !i_integrity_check_off
            && crc_fin != CRC_GOOD;
    endsequence

    property p_open_drain;
        o_sda_oe |-> !o_sda_o && !o_scl_oe;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_strap_addr;
        i_ce && !q.ovr && !i_ctl_addr_wr |=> o_slave_addr == {ADDR_FIXED, $past(q.strap2)};
    endproperty
    a_strap_addr: assert property (p_strap_addr) else $error("strap address wrong");
    property p_sw_addr;
        i_ce && i_ctl_addr_wr |=> o_slave_addr == $past(i_ctl_addr);
    endproperty
    a_sw_addr: assert property (p_sw_addr) else $error("software address lost");
    property p_wr_cmd;
        o_wr_req |-> q.cmd == CMD_WR && !q.pend && o_wr.addr[1:0] == 2'b00;
    endproperty
    a_wr_cmd: assert property (p_wr_cmd) else $error("write without write command");
    property p_rd_req;
        o_rd_req |-> q.rd_dir && q.setup && o_rd == q.rtgt;
    endproperty
    a_rd_req: assert property (p_rd_req) else $error("read without setup");
    property p_cnt_bad;
        s_cnt_bad |=> !q.ack && q.bad && !o_sda_oe;
    endproperty
    a_cnt_bad: assert property (p_cnt_bad) else $error("bad count accepted");
    property p_pec_bad;
        s_wpec_bad |=> !o_sda_oe && !q.pend && !o_wr_req;
    endproperty
    a_pec_bad: assert property (p_pec_bad) else $error("bad code accepted");
    property p_pec_off;
        rx_done && q.bidx == BI_WPEC && q.cmd == CMD_WR && i_integrity_check_off
            && !q.bad && q.pend |=> o_wr_req && o_sda_oe;
    endproperty
    a_pec_off: assert property (p_pec_off) else $error("check not skipped");
    property p_tx_cnt;
        $rose(q.st == ST_TX) && q.tidx == TI_CNT |-> q.sh == CNT_RET;
    endproperty
    a_tx_cnt: assert property (p_tx_cnt) else $error("count byte wrong");
    property p_tx_pec;
        $rose(q.st == ST_TX) && q.tidx == TI_PEC |-> q.sh == crc;
    endproperty
    a_tx_pec: assert property (p_tx_pec) else $error("returned code wrong");

endmodule // scr_slave

// >>> tb/scr_master.sv
// Bus master model: open-drain clock and data, 80 ns bit period.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module scr_master (
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    ////////////////////////////////////////////////////////////
    // Released lines idle high; the clock stands still between frames
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Start or repeated start; the tail gap keeps data off the clock edge
    task automatic start();
        o_sda = 1'b1;
        #20 o_scl = 1'b1;
        #20 o_sda = 1'b0;
        #20 o_scl = 1'b0;
        #20;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        #20 o_scl = 1'b1;
        #20 o_sda = 1'b1;
        #40;
    endtask
    // One clock pulse; data changes only while the clock is low
    task automatic clk_bit(input logic b, output logic r);
        o_sda = b;
        #20 o_scl = 1'b1;
        #20 r = i_sda;
        #20 o_scl = 1'b0;
        #20;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], r);
        end
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(last, r);
    endtask
endmodule // scr_master

// >>> tb/test_smbus_config_register_access.sv
// Self-checking bench of the management-bus slave.
// Assumes the slave answers on the data wire only; a stand-in register file.
`timescale 1ns/100ps
module test_smbus_config_register_access;
    import scr_pkg::*;
    logic i_clk, i_rst, i_ce, scl, msda, sda_oe, ctl_wr, chk_off, wr_req, rd_req, rd_ack;
    logic scl_o, scl_oe, sda_o;
    logic [2:0] strap;
    logic [6:0] ctl_addr, saddr;
    logic [31:0] rd_val;
    logic [15:0] acks;
    scr_wr_t wr, wr_seen;
    scr_tgt_t rd;
    int errors = 0, n_compared = 0, n_wr = 0;
    wire sda = msda & !sda_oe;
    scr_master u_mst (.o_scl(scl), .o_sda(msda), .i_sda(sda));
    scr_slave u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_scl(scl), .i_sda(sda),
        .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_strap(strap),
        .i_ctl_addr(ctl_addr), .i_ctl_addr_wr(ctl_wr), .i_integrity_check_off(chk_off),
        .o_slave_addr(saddr), .o_wr_req(wr_req), .o_wr(wr), .o_rd_req(rd_req), .o_rd(rd),
        .i_rd_ack(rd_ack), .i_rd_data(rd_val));
    ////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = !i_clk;
    end
    // Register file stand-in: answers a read next cycle, logs each write
    always @(negedge i_clk) begin
        rd_ack <= rd_req;
        if (wr_req === 1'b1) begin
            n_wr <= n_wr + 1;
            wr_seen <= wr;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] q[$]);
        logic [7:0] c = 8'h00;
        foreach (q[i]) begin
            c = c ^ q[i];
            repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    // Start, then bytes; acks gather newest in bit 0
    task automatic send(input logic [7:0] q[$]);
        logic a;
        acks = 16'h0000;
        u_mst.start();
        foreach (q[i]) begin
            u_mst.wbyte(q[i], a);
            acks = {acks[14:0], a};
        end
    endtask
    task automatic fin();
        u_mst.stop();
        repeat (10) @(negedge i_clk);
    endtask
    // Write with no code (0), good code (1) or corrupted code (2)
    task automatic t_write(input logic [7:0] b3, input int pec, input logic off, input logic ok);
        logic [7:0] q[$] = '{8'hD0, 8'hBE, 8'h08, 8'h03, 8'h05, b3, 8'h3E,
            8'h12, 8'h34, 8'h56, 8'h78};
        int n0 = n_wr;
        scr_wr_t w0 = wr_seen;
        scr_wr_t ex;
        chk_off = off;
        if (pec > 0) q.push_back(crc8(q) ^ (pec > 1 ? 8'h01 : 8'h00));
        send(q);
        fin();
        // A dropped write must leave the last landed one as it was
        ex = ok ? '{{4'h5, b3[7]}, {b3[1:0], 8'h3E, 2'b00}, b3[5:2], 32'h1234_5678} : w0;
        check("write acks", acks, pec == 0 ? 16'h07FF : {4'h0, 11'h7FF, ok});
        check("write count", n_wr - n0, ok);
        check("write port", wr_seen.port, ex.port);
        check("write addr", wr_seen.addr, ex.addr);
        check("write be", wr_seen.be, ex.be);
        check("write data", wr_seen.data, ex.data);
    endtask
    // Wrong count, wrong operation, wrong command: that byte and all after refused
    task automatic t_bad();
        int n0 = n_wr;
        send('{8'hD0, 8'hBE, 8'h07, 8'h03, 8'h05});
        fin();
        check("count acks", acks, 16'h0018);
        send('{8'hD0, 8'hBE, 8'h08, 8'h04, 8'h05});
        fin();
        check("op acks", acks, 16'h001C);
        send('{8'hD0, 8'hBB, 8'h08});
        fin();
        check("cmd acks", acks, 16'h0004);
        check("bad write count", n_wr - n0, 0);
    endtask
    // Read through setup then read (0) or through one process call (1)
    task automatic t_read(input logic pc, input logic [31:0] v);
        logic [7:0] q[$] = '{8'hD0, pc ? 8'hCD : 8'hBA, 8'h04, 8'h04, 8'h05, 8'hBC, 8'h3E};
        logic [7:0] e[$] = '{8'h04, v[31:24], v[23:16], v[15:8], v[7:0]};
        logic [7:0] b;
        logic a;
        rd_val = v;
        send(q);
        check("setup acks", acks, 16'h007F);
        if (!pc) begin
            fin();
            q = '{8'hD0, 8'hBD};
            send(q);
        end
        q = {q, 8'hD1, e};
        e.push_back(crc8(q));
        u_mst.start();
        u_mst.wbyte(8'hD1, a);
        check("read addr ack", a, 1'b1);
        foreach (e[i]) begin
            u_mst.rbyte(i == 5, b);
            check("read byte", b, e[i]);
            check("pin drive", {scl_o, scl_oe, sda_o}, 3'h0);
        end
        fin();
        check("read port", rd.port, 5'h0B);
        check("read addr", rd.addr, 12'h0F8);
    endtask
    task automatic t_addr();
        strap = 3'h5;
        repeat (6) @(negedge i_clk);
        check("strap addr", saddr, 7'h6D);
        send('{8'hD0});
        fin();
        check("old addr ack", acks, 16'h0000);
        ctl_addr = 7'h22;
        ctl_wr = 1'b1;
        @(negedge i_clk) ctl_wr = 1'b0;
        repeat (3) @(negedge i_clk);
        check("soft addr", saddr, 7'h22);
        send('{8'h44, 8'hBE});
        fin();
        check("soft addr acks", acks, 16'h0003);
        // With the enable low a load pulse must not reach the address
        i_ce = 1'b0;
        ctl_addr = 7'h11;
        ctl_wr = 1'b1;
        @(negedge i_clk) ctl_wr = 1'b0;
        i_ce = 1'b1;
        repeat (2) @(negedge i_clk);
        check("frozen addr", saddr, 7'h22);
    endtask
    task automatic end_of_test();
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence; every wait above is a fixed count
    initial begin
        {i_rst, i_ce, ctl_wr, chk_off} = 4'hC;
        {strap, ctl_addr, rd_val} = '0;
        repeat (16) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (6) @(negedge i_clk);
        check("reset addr", saddr, 7'h68);
        t_write(8'hBC, 0, 1'b0, 1'b1);
        t_write(8'h25, 1, 1'b0, 1'b1);
        t_write(8'hA2, 2, 1'b0, 1'b0);
        t_write(8'h0A, 2, 1'b1, 1'b1);
        t_bad();
        t_read(1'b0, 32'hCAFE_1234);
        t_read(1'b1, 32'h5A0F_00C3);
        t_addr();
        end_of_test();
    end
endmodule // test_smbus_config_register_access
